// [design/oip_pkg.sv]
// What this block does
// R1: pin works as inhibit (default), level input, or digital output
// R2: polarity setting inverts pin input or output; non-inverted is default
// R3: level inhibit with pin floating reads high and leaves output alone
// R4: level inhibit low while on forces output zero, indicator and display stay on
// R5: level inhibit releases automatically when pin returns to idle level
// R6: inverted polarity makes a high level the inhibiting level
// R7: level inhibit ramps output to zero and shows inhibit indication
// R8: latching inhibit pulse while on switches output off, indicator off
// R9: latching pulse low phase must last at least 30 us to count
// R10: after latch, output stays off with protection shown until manual turn-on
// R11: latching inhibit with pin floating never changes output state
// R12: output mode drives logic 1, logic 0 or configurable PWM
// R13: value false drives high non-inverted, low inverted
// R14: value true drives low non-inverted, high inverted
// R15: input mode samples pin, applies polarity, output state untouched
`default_nettype none
package oip_pkg;
  // pin function, Gray coded
  typedef enum logic [1:0] {
    OIP_FN_INHIBIT = 2'h0,
    OIP_FN_INPUT   = 2'h1,
    OIP_FN_OUTPUT  = 2'h3
  } oip_func_type;
  typedef enum logic [1:0] {
    OIP_OUT_FALSE = 2'h0,
    OIP_OUT_TRUE  = 2'h1,
    OIP_OUT_PWM   = 2'h3
  } oip_outsel_type;
  // pin configuration bundle
  typedef struct packed {
    oip_func_type   func;
    logic           invert;
    logic           latch_mode;
    oip_outsel_type out_sel;
  } oip_cfg_type;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned PULSE_MIN_NS   = 30000;
  localparam int unsigned PULSE_MIN_CYC  = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_CNT_W    = 16;
  localparam int unsigned PWM_W          = 16;
  localparam int unsigned RAMP_W         = 16;
  localparam logic [RAMP_W-1:0] RAMP_FULL = 16'hFFFF;
endpackage
`default_nettype wire

// [design/oip_top.sv]
`default_nettype none
module oip_top
  import oip_pkg::*;
#(
  parameter int unsigned PULSE_MIN = PULSE_MIN_CYC,
  parameter logic [RAMP_W-1:0] RAMP_STEP = 16'h0040
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  // configuration
  input  wire oip_cfg_type       cfg_i,
  input  wire logic [PWM_W-1:0]  pwm_period_i,
  input  wire logic [PWM_W-1:0]  pwm_high_i,
  // output on/off control
  input  wire logic              on_req_i,
  input  wire logic              off_req_i,
  // pin
  input  wire logic              pin_i,
  output logic                   pin_o,
  output logic                   pin_oe_o,
  // status
  output logic                   output_on_o,
  output logic                   output_enable_o,
  output logic [RAMP_W-1:0]      output_level_o,
  output logic                   inhibit_active_indication_o,
  output logic                   latched_protection_indication_o,
  output logic                   input_level_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_ff, rst_sync_ff;
  logic pin_ff;
  logic active_lvl;
  logic on_ff, latched_ff, inh_ff, in_lvl_ff, pin_out_ff, pwm_q_ff;
  logic [PULSE_CNT_W-1:0] low_cnt_ff;
  logic [PWM_W-1:0]       pwm_cnt_ff;
  logic [RAMP_W-1:0]      level_ff;
  logic inh_mode, lvl_mode, lat_mode, pulse_ok, nxt_pin_out;

  // pin function decode, shared by mode logic, input sampling and pad enable
  function automatic logic func_is(input oip_func_type sel, input oip_func_type want);
    return (sel == want);
  endfunction

  // reset release through two flops
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // pin sample, floating pin reads high through the pad pull-up
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) pin_ff <= 1'b1;
    else              pin_ff <= pin_i;
  end

  // pin level after polarity: high means asserted (inhibiting) level
  assign active_lvl = cfg_i.invert ? pin_ff : ~pin_ff;  // [R2] [R6]
  assign inh_mode   = func_is(cfg_i.func, OIP_FN_INHIBIT);  // [R1]
  assign lvl_mode   = inh_mode && !cfg_i.latch_mode;
  assign lat_mode   = inh_mode && cfg_i.latch_mode;

  ////////////////////////////////////////////////////////////////////////////
  // low-phase width counter for latching mode, saturating
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) low_cnt_ff <= '0;
    else if (!lat_mode || !active_lvl) low_cnt_ff <= '0;  // [R11]
    else if (low_cnt_ff != '1) low_cnt_ff <= low_cnt_ff + 1'b1;
  end
  // qualifying pulse seen exactly when width is first reached
  assign pulse_ok = lat_mode && active_lvl &&
                    (low_cnt_ff == PULSE_CNT_W'(PULSE_MIN - 1));  // [R9]

  // on/off state and protection latch; manual turn-on clears latch
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      on_ff      <= 1'b0;
      latched_ff <= 1'b0;
    end else if (pulse_ok && on_ff) begin
      on_ff      <= 1'b0;  // [R8]
      latched_ff <= 1'b1;  // [R10]
    end else if (on_req_i) begin
      on_ff      <= 1'b1;
      latched_ff <= 1'b0;  // [R10]
    end else if (off_req_i) begin
      on_ff      <= 1'b0;
    end
  end

  // level inhibit flag; idle pin (high) leaves output alone
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) inh_ff <= 1'b0;
    else              inh_ff <= lvl_mode && on_ff && active_lvl;  // [R3] [R4] [R5]
  end

  // output ramp: down to zero while inhibited, back up on release
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) level_ff <= '0;
    else if (!on_ff) level_ff <= '0;
    else if (inh_ff) level_ff <= (level_ff > RAMP_STEP) ? level_ff - RAMP_STEP : '0;  // [R7]
    else level_ff <= (RAMP_FULL - level_ff > RAMP_STEP) ? level_ff + RAMP_STEP
                                                         : RAMP_FULL;  // [R5]
  end

  // input mode sampled level after polarity
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) in_lvl_ff <= 1'b0;
    else if (func_is(cfg_i.func, OIP_FN_INPUT)) in_lvl_ff <= active_lvl;  // [R15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm generator
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pwm_cnt_ff <= '0;
      pwm_q_ff   <= 1'b0;
    end else begin
      pwm_cnt_ff <= (pwm_cnt_ff >= pwm_period_i) ? '0 : pwm_cnt_ff + 1'b1;
      pwm_q_ff   <= (pwm_cnt_ff < pwm_high_i);  // [R12]
    end
  end

  // logical true drives low unless inverted
  always_comb begin
    case (cfg_i.out_sel)
      OIP_OUT_TRUE:  nxt_pin_out = cfg_i.invert;   // [R14]
      OIP_OUT_FALSE: nxt_pin_out = ~cfg_i.invert;  // [R13]
      OIP_OUT_PWM:   nxt_pin_out = pwm_q_ff ^ ~cfg_i.invert;  // [R12]
      default:       nxt_pin_out = ~cfg_i.invert;
    endcase
  end

  // registered pad value, idles high like a released pin
  always_ff @(posedge sys_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) pin_out_ff <= 1'b1;
    else              pin_out_ff <= nxt_pin_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pin_o                           = pin_out_ff;
  assign pin_oe_o                        = func_is(cfg_i.func, OIP_FN_OUTPUT);  // [R1]
  assign output_on_o                     = on_ff;  // [R4]
  assign output_enable_o                 = on_ff && !inh_ff;
  assign output_level_o                  = level_ff;
  assign inhibit_active_indication_o     = inh_ff;  // [R7]
  assign latched_protection_indication_o = latched_ff;
  assign input_level_o                   = in_lvl_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_sync_ff);

  lvl_inh_set_a: assert property (lvl_mode && on_ff && active_lvl && !off_req_i
                   |=> inh_ff && on_ff)  // [R4]
    else $error("level inhibit not raised");
  lvl_release_a: assert property (inh_ff && lvl_mode && !active_lvl |=> !inh_ff)  // [R5]
    else $error("level inhibit not released");
  idle_pin_a: assert property (inh_mode && !cfg_i.invert && pin_ff |=> !inh_ff)  // [R3]
    else $error("idle pin inhibited output");
  ramp_down_a: assert property (inh_ff && on_ff && level_ff != '0
                  |=> level_ff < $past(level_ff))  // [R7]
    else $error("output not ramping down");
  latch_off_a: assert property (pulse_ok && on_ff |=> !on_ff && latched_ff)  // [R8]
    else $error("latch pulse did not switch off");
  short_pulse_a: assert property (lat_mode && on_ff && !on_req_i && !off_req_i
                   && low_cnt_ff < PULSE_CNT_W'(PULSE_MIN - 1) |=> on_ff)  // [R9]
    else $error("short pulse switched off");
  latch_hold_a: assert property (latched_ff && !on_req_i |=> latched_ff && !on_ff)  // [R10]
    else $error("latch released without turn-on");
  float_latch_a: assert property (lat_mode && pin_ff && !cfg_i.invert && on_ff
                   && !off_req_i |=> on_ff)  // [R11]
    else $error("floating pin changed output");
  out_level_a: assert property (cfg_i.out_sel == OIP_OUT_TRUE && $stable(cfg_i)
                 |=> pin_o == $past(cfg_i.invert))  // [R14]
    else $error("true level wrong");
  in_keep_a: assert property (cfg_i.func == OIP_FN_INPUT |=> !inh_ff)  // [R15]
    else $error("input mode touched output");

  // non-inhibit functions never touch the on/off state
  mode_gate_a: assert property (!inh_mode && !on_req_i && !off_req_i  // [R1]
                 |=> on_ff == $past(on_ff) && !inh_ff)
    else $error("on state changed outside inhibit");

  // false value drives the idle level unless inverted
  false_level_a: assert property (cfg_i.out_sel == OIP_OUT_FALSE  // [R13]
                   |=> pin_o == !$past(cfg_i.invert))
    else $error("false level wrong");

  // pwm waveform reaches the pad with polarity applied
  pwm_drive_a: assert property (cfg_i.out_sel == OIP_OUT_PWM  // [R12]
                 |=> pin_o == ($past(pwm_q_ff) ^ !$past(cfg_i.invert)))
    else $error("pwm level wrong");

  // inverted polarity makes a high pin inhibit
  inv_inhibit_a: assert property (lvl_mode && cfg_i.invert && on_ff && pin_ff  // [R6]
                   && !off_req_i |=> inh_ff)
    else $error("inverted inhibit not raised");

  // manual turn-on clears the protection latch
  turn_on_a: assert property (on_req_i && !(pulse_ok && on_ff)  // [R10]
               |=> on_ff && !latched_ff)
    else $error("turn-on did not clear latch");

  // input mode follows the pin with polarity applied
  input_follow_a: assert property (cfg_i.func == OIP_FN_INPUT  // [R15]
                    |=> input_level_o == ($past(pin_ff) ^ !$past(cfg_i.invert)))
    else $error("input level wrong");

  // released inhibit ramps the output back up
  ramp_up_a: assert property (on_ff && !inh_ff && !off_req_i && !pulse_ok  // [R5]
               && level_ff != RAMP_FULL |=> level_ff > $past(level_ff))
    else $error("output not recovering");

  // main scenarios
  lvl_cov_c: cover property (inh_ff ##1 !inh_ff);
  inv_cov_c: cover property (lvl_mode && cfg_i.invert && inh_ff);
  lat_fall_cov_c: cover property (lat_mode && on_ff && $fell(pin_ff));
  latch_cov_c: cover property (pulse_ok && on_ff);
  pwm_cov_c: cover property (pin_oe_o && cfg_i.out_sel == OIP_OUT_PWM && $rose(pin_o));
endmodule
`default_nettype wire

// [verification/oip_ext_ctrl.sv]
`default_nettype none
module oip_ext_ctrl (
  // commands from the bench
  input  wire logic drive_en_i,
  input  wire logic drive_lvl_i,
  // device side of the pin
  input  wire logic pin_drv_i,
  input  wire logic pin_oe_i,
  // resolved wire level
  output logic      wire_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // device drive wins, else controller, else pull-up holds the idle high
  assign wire_lvl_o = pin_oe_i ? pin_drv_i : (drive_en_i ? drive_lvl_i : 1'b1);
endmodule
`default_nettype wire

// [verification/output_inhibit_io_pin_tb.sv]
`default_nettype none
module output_inhibit_io_pin_tb
  import oip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, on_req, off_req, drv_en, drv_lvl, pin, pin_o, pin_oe;
  logic on, en, inhibit_active_indication, lat, in_lvl;
  logic [15:0] lvl, per, hi;
  oip_cfg_type cfg;
  int num_errors, total_checks, cyc, ones;
  wire logic [3:0] st = {on, en, inhibit_active_indication, lat};
  oip_top #(.PULSE_MIN(10), .RAMP_STEP(16'h4000)) u_oip_top (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .cfg_i(cfg), .pwm_period_i(per),
    .pwm_high_i(hi), .on_req_i(on_req), .off_req_i(off_req), .pin_i(pin),
    .pin_o(pin_o), .pin_oe_o(pin_oe), .output_on_o(on), .output_enable_o(en),
    .output_level_o(lvl), .inhibit_active_indication_o(inhibit_active_indication),
    .latched_protection_indication_o(lat), .input_level_o(in_lvl));
  oip_ext_ctrl u_oip_ext_ctrl (.drive_en_i(drv_en), .drive_lvl_i(drv_lvl),
    .pin_drv_i(pin_o), .pin_oe_i(pin_oe), .wire_lvl_o(pin));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and cycle ceiling
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_lvl(input logic [15:0] target);
    for (int i = 0; i < 50 && lvl !== target; i++) tick(1);
    chk(lvl, target);
  endtask
  task automatic drive(input logic e, input logic v, input int n);
    drv_en = e;
    drv_lvl = v;
    tick(n);
  endtask
  task automatic turn_on;
    on_req = 1'b1;
    tick(1);
    on_req = 1'b0;
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    cfg = '{func: OIP_FN_INHIBIT, invert: 1'b0, latch_mode: 1'b0, out_sel: OIP_OUT_FALSE};
    {reset_n, on_req, off_req, drv_en, drv_lvl} = 5'h01;
    per = 16'h0003;
    hi = 16'h0001;
    tick(2);
    reset_n = 1'b1;
    tick(3);
    chk(16'({st, pin_o}), 16'h0001);
    turn_on();
    chk(16'(st), 16'h000C);
    wait_lvl(16'hFFFF);
    drive(1'b1, 1'b0, 4);
    chk(16'(st), 16'h000A);
    wait_lvl(16'h0000);
    drive(1'b0, 1'b0, 4);
    chk(16'(st), 16'h000C);
    wait_lvl(16'hFFFF);
    cfg.invert = 1'b1;
    tick(4);
    chk(16'(st), 16'h000A);
    drive(1'b1, 1'b0, 4);
    chk(16'(st), 16'h000C);
    cfg = '{func: OIP_FN_INHIBIT, invert: 1'b0, latch_mode: 1'b1, out_sel: OIP_OUT_FALSE};
    drive(1'b0, 1'b0, 4);
    drive(1'b1, 1'b0, 9);
    drive(1'b0, 1'b0, 4);
    chk(16'(st), 16'h000C);
    drive(1'b1, 1'b0, 12);
    drive(1'b0, 1'b0, 20);
    chk(16'(st), 16'h0001);
    turn_on();
    tick(30);
    chk(16'(st), 16'h000C);
    cfg.func = OIP_FN_INPUT;
    cfg.latch_mode = 1'b0;
    for (int a = 0; a < 4; a++) begin
      cfg.invert = a[1];
      drive(1'b1, a[0], 4);
      chk(16'({pin_oe, in_lvl, on}), 16'({1'b0, ~(a[0] ^ a[1]), 1'b1}));
    end
    drive(1'b0, 1'b0, 1);
    cfg.func = OIP_FN_OUTPUT;
    for (int a = 0; a < 4; a++) begin
      cfg.invert = a[1];
      cfg.out_sel = a[0] ? OIP_OUT_TRUE : OIP_OUT_FALSE;
      tick(3);
      chk(16'({pin_oe, pin}), 16'({1'b1, ~(a[0] ^ a[1])}));
    end
    cfg.invert = 1'b0;
    cfg.out_sel = OIP_OUT_PWM;
    tick(8);
    ones = 0;
    repeat (8) begin
      tick(1);
      ones += int'(pin_o);
    end
    chk(16'(ones), 16'h0006);
    finish_test();
  end
endmodule
`default_nettype wire
